// File: core/poe_cfg_regs.svh
// register offsets, field positions, reset values and timing counts for the port config bank
`ifndef POE_CFG_REGS_SVH
`define POE_CFG_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define POE_ADDR_STRAP_STATUS   8'h11
`define POE_ADDR_OPER_MODE      8'h12
`define POE_ADDR_DISC_ENABLE    8'h13
`define POE_ADDR_DETCLS_ENABLE  8'h14
`define POE_ADDR_CADENCE_ENABLE 8'h15

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POE_STRAP_AUTO_BIT      0
`define POE_STRAP_ID_LSB        2
`define POE_STRAP_GROUP_LSB     4
`define POE_CLASS_EN_LSB        4
`define POE_PORT_COUNT          4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define POE_MODE_RST_AUTO       8'hFF
`define POE_DISC_RST_AUTO       8'hF0
`define POE_DETCLS_RST_AUTO     8'hFF
`define POE_RST_MANUAL          8'h00
`define POE_CADENCE_RST_HI      4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define POE_CLK_HZ              200000000
`define POE_CADENCE_TIME_S      2
`define POE_CADENCE_CYCLES      (`POE_CADENCE_TIME_S * `POE_CLK_HZ)
`define POE_CADENCE_CNT_W       29

`endif

// File: core/poe_cfg_pkg.sv
// types and mode decoding shared by the port config bank
package poe_cfg_pkg;

    `include "poe_cfg_regs.svh"

    // ----------------------------------------------------------------
    // port operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_MANUAL   = 2'b01,
        MODE_SEMIAUTO = 2'b10,
        MODE_AUTO     = 2'b11
    } port_mode_type;

    function automatic port_mode_type port_mode(input logic [7:0] mode_reg, input int idx);
        port_mode_type m;
        m = port_mode_type'(mode_reg[2*idx +: 2]);
        return m;
    endfunction

endpackage

// File: core/strap_latch.sv
// strap sampler: captures the strap pins once each time a reset condition clears
`timescale 1ns/1ps
module strap_latch (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_restart,
    // strap pins
    input  wire logic       i_auto,
    input  wire logic       i_addr_strap_3,
    input  wire logic       i_addr_strap_2,
    input  wire logic       i_addr_strap_1,
    input  wire logic       i_addr_strap_0,
    input  wire logic       i_midspan,
    // latched values
    output logic [7:0]      o_status,
    output logic            o_midspan,
    output logic            o_loaded
);

    logic pending;

    // pins cannot be taken under async reset, so capture waits for the first edge after release
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pending <= 1'b1;
        end else if (i_restart) begin
            pending <= 1'b1;
        end else begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_status  <= 8'h00;
            o_midspan <= 1'b0;
        end else if (pending && !i_restart) begin
            o_status  <= {2'b00, i_addr_strap_3, i_addr_strap_2,
                          i_addr_strap_1, i_addr_strap_0, 1'b0, i_auto};
            o_midspan <= i_midspan;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_loaded <= 1'b0;
        end else begin
            o_loaded <= pending && !i_restart;
        end
    end

endmodule

// File: core/cadence_timer.sv
// per-port back-off timer that holds detection off after a failed detection
`timescale 1ns/1ps
`include "poe_cfg_regs.svh"
module cadence_timer #(
    parameter logic [`POE_CADENCE_CNT_W-1:0] HOLD_CYCLES = `POE_CADENCE_CNT_W'(`POE_CADENCE_CYCLES)
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_restart,
    // control
    input  wire logic       i_enable,
    input  wire logic       i_fail,
    // status
    output logic            o_holdoff
);

    logic [`POE_CADENCE_CNT_W-1:0] count;

    // a running back-off finishes even if the enable drops; only a reset or restart cuts the wait short
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count     <= '0;
            o_holdoff <= 1'b0;
        end else if (i_restart) begin
            count     <= '0;
            o_holdoff <= 1'b0;
        end else if (i_fail && i_enable) begin
            count     <= HOLD_CYCLES;
            o_holdoff <= 1'b1;
        end else if (count != '0) begin
            count     <= count - `POE_CADENCE_CNT_W'(1);
            o_holdoff <= (count != `POE_CADENCE_CNT_W'(1));
        end
    end

endmodule

// File: core/poe_port_config_registers.sv
// configuration and strap status register bank of a four-port power-sourcing controller
//
// Function
// - strap status: auto bit0, address straps 5:2
// - low address straps stored as identifier 3:2
// - straps captured at reset release only
// - port group field selects controlled quad
// - two mode bits per port, four ports
// - modes: shutdown, manual, semiautomatic, automatic
// - mode resets FFh with auto, else 00h
// - disconnect enable resets F0h with auto
// - disconnect on when either nibble bit set
// - detect/classify enable resets FFh with auto
// - automatic modes: bits enable detect, classify
// - manual: written bit launches, clears when done
// - shutdown port ignores detect/classify writes
// - cadence resets to latched midspan strap
// - cadence: wait 2 s after failed detection
// - strap read-only, other fields read/write
`timescale 1ns/1ps
`include "poe_cfg_regs.svh"
module poe_port_config_registers
    import poe_cfg_pkg::*;
#(
    parameter int unsigned CADENCE_CYCLES = `POE_CADENCE_CYCLES
) (
    // clock and reset
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RESETN,
    input  wire logic       I_SW_RESET,
    // strap pins
    input  wire logic       I_STRAP_AUTO,
    input  wire logic       I_ADDR_STRAP_3,
    input  wire logic       I_ADDR_STRAP_2,
    input  wire logic       I_ADDR_STRAP_1,
    input  wire logic       I_ADDR_STRAP_0,
    input  wire logic       I_STRAP_MIDSPAN,
    // register access port
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    output logic [7:0]      O_REG_RDATA,
    output logic            O_REG_RVALID,
    output logic            O_CFG_READY,
    // engine status
    input  wire logic [3:0] I_DET_DONE,
    input  wire logic [3:0] I_CLASS_DONE,
    input  wire logic [3:0] I_DET_FAIL,
    // port controls
    output logic [7:0]      O_PORT_MODE,
    output logic [1:0]      O_PORT_GROUP,
    output logic [3:0]      O_DISCONNECT_EN,
    output logic [3:0]      O_DETECT_EN,
    output logic [3:0]      O_CLASSIFY_EN,
    output logic [3:0]      O_DET_HOLDOFF
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] strap_status;
    logic       midspan_latched;
    logic       loaded;
    logic       ready;
    logic [7:0] mode;
    logic [7:0] disc;
    logic [7:0] detcls;
    logic [3:0] cadence;
    logic [3:0] holdoff;
    logic [7:0] next_detcls;
    logic [3:0] next_detect;
    logic [3:0] next_classify;
    logic [3:0] port_shutdown_mode_mask;
    logic       strap_auto;
    logic       wr_mode;
    logic       wr_disc;
    logic       wr_detcls;
    logic       wr_cadence;

    function automatic logic reg_mapped(input logic [7:0] addr);
        return (addr >= `POE_ADDR_STRAP_STATUS) && (addr <= `POE_ADDR_CADENCE_ENABLE);
    endfunction

    // ----------------------------------------------------------------
    // strap capture and cadence timers
    // ----------------------------------------------------------------
    strap_latch u_strap (
        .i_clk          (I_CLK_SYS),
        .i_resetn       (I_RESETN),
        .i_restart      (I_SW_RESET),
        .i_auto         (I_STRAP_AUTO),
        .i_addr_strap_3 (I_ADDR_STRAP_3),
        .i_addr_strap_2 (I_ADDR_STRAP_2),
        .i_addr_strap_1 (I_ADDR_STRAP_1),
        .i_addr_strap_0 (I_ADDR_STRAP_0),
        .i_midspan      (I_STRAP_MIDSPAN),
        .o_status       (strap_status),
        .o_midspan      (midspan_latched),
        .o_loaded       (loaded)
    );

    for (genvar p = 0; p < `POE_PORT_COUNT; p++) begin : g_cadence
        cadence_timer #(
            .HOLD_CYCLES (`POE_CADENCE_CNT_W'(CADENCE_CYCLES))
        ) u_timer (
            .i_clk      (I_CLK_SYS),
            .i_resetn   (I_RESETN),
            .i_restart  (I_SW_RESET),
            .i_enable   (cadence[p]),
            .i_fail     (I_DET_FAIL[p]),
            .o_holdoff  (holdoff[p])
        );
    end

    assign strap_auto    = strap_status[`POE_STRAP_AUTO_BIT];
    assign O_PORT_GROUP  = strap_status[`POE_STRAP_GROUP_LSB +: 2];
    assign O_DET_HOLDOFF = holdoff;
    assign O_PORT_MODE   = mode;
    assign O_CFG_READY   = ready;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    // writes before the defaults are loaded would be overwritten, so they are dropped
    assign wr_mode    = I_REG_WR && ready && (I_REG_ADDR == `POE_ADDR_OPER_MODE);
    assign wr_disc    = I_REG_WR && ready && (I_REG_ADDR == `POE_ADDR_DISC_ENABLE);
    assign wr_detcls  = I_REG_WR && ready && (I_REG_ADDR == `POE_ADDR_DETCLS_ENABLE);
    assign wr_cadence = I_REG_WR && ready && (I_REG_ADDR == `POE_ADDR_CADENCE_ENABLE);

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ready <= 1'b0;
        end else if (I_SW_RESET) begin
            ready <= 1'b0;
        end else if (loaded) begin
            ready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // only the reset load and host writes reach the mode field
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mode <= `POE_RST_MANUAL;
        end else if (loaded) begin
            mode <= strap_auto ? `POE_MODE_RST_AUTO : `POE_RST_MANUAL;
        end else if (wr_mode) begin
            mode <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            disc <= `POE_RST_MANUAL;
        end else if (loaded) begin
            disc <= strap_auto ? `POE_DISC_RST_AUTO : `POE_RST_MANUAL;
        end else if (wr_disc) begin
            disc <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cadence <= 4'h0;
        end else if (loaded) begin
            cadence <= {`POE_PORT_COUNT{midspan_latched}};
        end else if (wr_cadence) begin
            cadence <= I_REG_WDATA[3:0];
        end
    end

    // a host write of 1 in the cycle of a done still launches again
    always_comb begin
        next_detcls = detcls;
        port_shutdown_mode_mask   = 4'h0;
        for (int p = 0; p < `POE_PORT_COUNT; p++) begin
            port_shutdown_mode_mask[p] = (port_mode(mode, p) == MODE_SHUTDOWN);
            if (port_mode(mode, p) == MODE_MANUAL) begin
                if (I_DET_DONE[p]) begin
                    next_detcls[p] = 1'b0;
                end
                if (I_CLASS_DONE[p]) begin
                    next_detcls[p + `POE_CLASS_EN_LSB] = 1'b0;
                end
            end
            if (wr_detcls && !port_shutdown_mode_mask[p]) begin
                next_detcls[p] = I_REG_WDATA[p];
                next_detcls[p + `POE_CLASS_EN_LSB] = I_REG_WDATA[p + `POE_CLASS_EN_LSB];
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            detcls <= `POE_RST_MANUAL;
        end else if (loaded) begin
            detcls <= strap_auto ? `POE_DETCLS_RST_AUTO : `POE_RST_MANUAL;
        end else begin
            detcls <= next_detcls;
        end
    end

    // ----------------------------------------------------------------
    // port controls
    // ----------------------------------------------------------------
    always_comb begin
        next_detect   = 4'h0;
        next_classify = 4'h0;
        for (int p = 0; p < `POE_PORT_COUNT; p++) begin
            next_detect[p]   = detcls[p] && !port_shutdown_mode_mask[p] && !holdoff[p];
            next_classify[p] = detcls[p + `POE_CLASS_EN_LSB] && !port_shutdown_mode_mask[p];
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_DETECT_EN     <= 4'h0;
            O_CLASSIFY_EN   <= 4'h0;
            O_DISCONNECT_EN <= 4'h0;
        end else begin
            O_DETECT_EN     <= next_detect;
            O_CLASSIFY_EN   <= next_classify;
            O_DISCONNECT_EN <= disc[7:4] | disc[3:0];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_REG_RDATA  <= 8'h00;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD && reg_mapped(I_REG_ADDR);
            case (I_REG_ADDR)
                `POE_ADDR_STRAP_STATUS:   O_REG_RDATA <= strap_status;
                `POE_ADDR_OPER_MODE:      O_REG_RDATA <= mode;
                `POE_ADDR_DISC_ENABLE:    O_REG_RDATA <= disc;
                `POE_ADDR_DETCLS_ENABLE:  O_REG_RDATA <= detcls;
                `POE_ADDR_CADENCE_ENABLE: O_REG_RDATA <= {`POE_CADENCE_RST_HI, cadence};
                default:                  O_REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESETN);
    logic rd_strap;
    assign rd_strap = I_REG_RD && (I_REG_ADDR == `POE_ADDR_STRAP_STATUS);

    AST_STRAP_LAYOUT: assert property (
        rd_strap |=> O_REG_RVALID && (O_REG_RDATA[7:6] == 2'b00) && !O_REG_RDATA[1]
    ) else $error("strap status reserved bits not zero");

    AST_STRAP_ID: assert property (
        loaded |-> strap_status[3:2] == $past({I_ADDR_STRAP_1, I_ADDR_STRAP_0})
    ) else $error("identifier field differs from captured straps");

    AST_STRAP_FROZEN: assert property (
        ready && !I_SW_RESET |=> $stable(strap_status)
    ) else $error("strap status changed during operation");

    AST_GROUP_READ: assert property (
        rd_strap |=> O_REG_RDATA[5:4] == $past(O_PORT_GROUP)
    ) else $error("port group output differs from strap status");

    AST_MODE_WRITE: assert property (
        wr_mode && !loaded |=> O_PORT_MODE == $past(I_REG_WDATA)
    ) else $error("mode write not stored");

    AST_PORT_SHUTDOWN_MODE_NO_DETECT: assert property (
        O_DETECT_EN[0] |-> $past(mode[1:0]) != MODE_SHUTDOWN
    ) else $error("detection enabled on a shutdown port");

    AST_MODE_DEFAULT: assert property (
        loaded |=> mode == (strap_auto ? 8'hFF : 8'h00)
    ) else $error("mode reset value wrong");

    AST_MODE_HOLD: assert property (
        !wr_mode && !loaded |=> $stable(mode)
    ) else $error("mode changed without a write");

    AST_DISC_DEFAULT: assert property (
        loaded |=> disc == (strap_auto ? 8'hF0 : 8'h00)
    ) else $error("disconnect enable reset value wrong");

    AST_DISC_OR: assert property (
        ##1 O_DISCONNECT_EN == ($past(disc[7:4]) | $past(disc[3:0]))
    ) else $error("disconnect enable not the or of both nibbles");

    AST_DETCLS_DEFAULT: assert property (
        loaded |=> detcls == (strap_auto ? 8'hFF : 8'h00)
    ) else $error("detect/classify enable reset value wrong");

    AST_AUTO_DETECT: assert property (
        (mode[1:0] == MODE_AUTO) && detcls[0] && !holdoff[0] |=> O_DETECT_EN[0]
    ) else $error("enabled detection not driven in automatic mode");

    AST_MANUAL_CLEAR: assert property (
        (mode[3:2] == MODE_MANUAL) && I_DET_DONE[1] && !wr_detcls && !loaded |=> !detcls[1]
    ) else $error("manual detection bit not cleared on completion");

    AST_PORT_SHUTDOWN_MODE_IGNORE: assert property (
        !loaded |=> ((detcls ^ $past(detcls)) & $past({port_shutdown_mode_mask, port_shutdown_mode_mask})) == 8'h00
    ) else $error("shutdown port enable bits changed");

    AST_CADENCE_DEFAULT: assert property (
        loaded |=> cadence == {4{midspan_latched}}
    ) else $error("cadence enable reset value wrong");

    AST_HOLDOFF: assert property (disable iff (!I_RESETN || I_SW_RESET)
        I_DET_FAIL[3] && cadence[3] |=> O_DET_HOLDOFF[3] [*8] ##1 !O_DETECT_EN[3]
    ) else $error("back-off not held after failed detection");

    AST_CADENCE_RSVD: assert property (
        I_REG_RD && (I_REG_ADDR == `POE_ADDR_CADENCE_ENABLE) |=> O_REG_RDATA[7:4] == 4'h0
    ) else $error("cadence reserved bits not zero");

    AST_STRAP_RO: assert property (
        I_REG_WR && (I_REG_ADDR == `POE_ADDR_STRAP_STATUS) && ready && !I_SW_RESET
            |=> $stable(strap_status)
    ) else $error("strap status written by host");

    COV_AUTO_LOAD:     cover property (loaded && strap_auto);
    COV_MANUAL_DONE:   cover property ((mode[3:2] == MODE_MANUAL) && detcls[1] ##1 !detcls[1]);
    COV_HOLDOFF:       cover property (I_DET_FAIL[3] && cadence[3] ##1 O_DET_HOLDOFF[3]);
    COV_PORT_SHUTDOWN_MODE_WRITE:    cover property (wr_detcls && port_shutdown_mode_mask[0]);

endmodule

// File: tb/engine_model.sv
// engine model: answers detection and classification requests with done pulses
`timescale 1ns/1ps
module engine_model #(
    parameter int DET_DELAY = 1,
    parameter int CLS_DELAY = 6
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // requests from the bank, and the fail request from the bench
    input  wire logic [3:0] i_detection_enable,
    input  wire logic [3:0] i_cls_en,
    input  wire logic [3:0] i_fail_req,
    // engine status
    output logic [3:0]      o_det_done,
    output logic [3:0]      o_cls_done,
    output logic [3:0]      o_det_fail
);
    logic [3:0] det_q;
    logic [3:0] cls_q;
    int         det_cnt [4];
    int         cls_cnt [4];

    // one cycle per rising request; a held enable does not retrigger
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            det_q      <= 4'h0;
            cls_q      <= 4'h0;
            o_det_done <= 4'h0;
            o_cls_done <= 4'h0;
            o_det_fail <= 4'h0;
            det_cnt    <= '{default: 0};
            cls_cnt    <= '{default: 0};
        end else begin
            det_q      <= i_detection_enable;
            cls_q      <= i_cls_en;
            o_det_fail <= i_fail_req;
            for (int p = 0; p < 4; p++) begin
                o_det_done[p] <= (det_cnt[p] == 1);
                o_cls_done[p] <= (cls_cnt[p] == 1);
                det_cnt[p]    <= (i_detection_enable[p] && !det_q[p]) ? DET_DELAY :
                                 (det_cnt[p] != 0) ? det_cnt[p] - 1 : 0;
                cls_cnt[p]    <= (i_cls_en[p] && !cls_q[p]) ? CLS_DELAY :
                                 (cls_cnt[p] != 0) ? cls_cnt[p] - 1 : 0;
            end
        end
    end
endmodule

// File: tb/tb_poe_port_config_registers.sv
// self-checking bench for the port config register bank
`timescale 1ns/1ps
module tb_poe_port_config_registers;
    import poe_cfg_pkg::*;
    // short hold keeps the back-off test quick
    localparam int unsigned HOLD = 16;
    logic       clk, rst_n, sw_rst, s_auto, s_mid, rd, wr, rvalid, ready;
    logic [3:0] s_adr, det_done, cls_done, det_fail, fail_req, disc_en, detection_enable, cls_en, hold;
    logic [7:0] addr, wdata, rdata, pmode;
    logic [1:0] group;
    int         num_errors, checks_done, n, d;
    int         m_strap, m_mode, m_disc, m_det, m_cad;

    poe_port_config_registers #(.CADENCE_CYCLES(HOLD)) dut_u (
        .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_SW_RESET(sw_rst), .I_STRAP_AUTO(s_auto),
        .I_ADDR_STRAP_3(s_adr[3]), .I_ADDR_STRAP_2(s_adr[2]), .I_ADDR_STRAP_1(s_adr[1]),
        .I_ADDR_STRAP_0(s_adr[0]), .I_STRAP_MIDSPAN(s_mid), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .O_CFG_READY(ready), .I_DET_DONE(det_done), .I_CLASS_DONE(cls_done),
        .I_DET_FAIL(det_fail), .O_PORT_MODE(pmode), .O_PORT_GROUP(group),
        .O_DISCONNECT_EN(disc_en), .O_DETECT_EN(detection_enable), .O_CLASSIFY_EN(cls_en),
        .O_DET_HOLDOFF(hold));

    engine_model eng_u (
        .i_clk(clk), .i_resetn(rst_n), .i_detection_enable(detection_enable), .i_cls_en(cls_en),
        .i_fail_req(fail_req), .o_det_done(det_done), .o_cls_done(cls_done),
        .o_det_fail(det_fail));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic bail();
        num_errors++;
        $display("ERROR t=%0t wait ran out", $time);
        finish_test();
    endtask

    // ----------------------------------------------------------------
    // register port and model
    // ----------------------------------------------------------------
    task automatic reg_read(input logic [7:0] a, input int exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({7'h0, rvalid}, 8'h01);
        check(rdata, 8'(exp));
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        if (a == 8'h12) m_mode = v;
        if (a == 8'h13) m_disc = v;
        if (a == 8'h15) m_cad = v & 8'h0F;
        for (int p = 0; p < 4 && a == 8'h14; p++) begin
            if (((m_mode >> (2 * p)) & 3) != 0) m_det = (m_det & ~(17 << p)) | (v & (17 << p));
        end
    endtask

    // manual ports lose their request bits once the engine reports done
    task automatic model_done();
        for (int p = 0; p < 4; p++) begin
            if (((m_mode >> (2 * p)) & 3) == 1) m_det = m_det & ~(17 << p);
        end
    endtask

    task automatic wait_ready_and_load();
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready !== 1'b1) bail();
        m_strap = {s_adr, 1'b0, s_auto};
        m_mode  = s_auto ? 8'hFF : 8'h00;
        m_disc  = s_auto ? 8'hF0 : 8'h00;
        m_det   = s_auto ? 8'hFF : 8'h00;
        m_cad   = s_mid ? 8'h0F : 8'h00;
        reg_read(8'h11, m_strap);
        reg_read(8'h12, m_mode);
        reg_read(8'h13, m_disc);
        reg_read(8'h14, m_det);
        reg_read(8'h15, m_cad);
        check({6'h0, group}, 8'((m_strap >> 4) & 3));
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hBD74638A));
        num_errors = 0;
        checks_done = 0;
        {rst_n, sw_rst, rd, wr, addr, wdata, fail_req} = '0;
        {s_auto, s_mid} = 2'b11;
        s_adr = 4'($urandom);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_ready_and_load();
        check({4'h0, detection_enable}, 8'h0F);
        check(pmode, 8'hFF);
        s_adr  <= ~s_adr;
        s_auto <= 1'b0;
        reg_write(8'h11, 8'hFF);
        reg_read(8'h11, m_strap);
        reg_write(8'h15, 8'hFF);
        reg_read(8'h15, m_cad);
        repeat (4) begin
            d = $urandom & 8'hFF;
            reg_write(8'h13, 8'(d));
            reg_read(8'h13, m_disc);
            check({4'h0, disc_en}, 8'((d >> 4) | (d & 15)));
        end
        @(posedge clk);
        rd   <= 1'b1;
        addr <= 8'h16;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({7'h0, rvalid}, 8'h00);
        check(rdata, 8'h00);
        // second start through the software reset, auto and midspan straps low this time
        @(posedge clk);
        {s_auto, s_mid} <= 2'b00;
        s_adr  <= 4'($urandom);
        sw_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sw_rst <= 1'b0;
        @(posedge clk);
        wait_ready_and_load();
        // ports 1..4: shutdown, manual, semiautomatic, automatic
        reg_write(8'h12, 8'hE4);
        reg_read(8'h12, m_mode);
        reg_write(8'h14, 8'hFF);
        repeat (20) @(posedge clk);
        model_done();
        reg_read(8'h14, m_det);
        #1;
        check({cls_en, detection_enable}, 8'hCC);
        // back-off on port 4 only, port 3 fails without cadence
        reg_write(8'h15, 8'h08);
        @(posedge clk);
        fail_req <= 4'b1100;
        @(posedge clk);
        fail_req <= 4'b0000;
        n = 0;
        while (hold[3] !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (hold[3] !== 1'b1) bail();
        n = 0;
        while (hold[3] === 1'b1 && n < 100) begin
            if (n == 2) check({6'h0, hold[2], detection_enable[3]}, 8'h00);
            @(posedge clk);
            #1;
            n++;
        end
        check(8'(n), 8'(HOLD));
        repeat (2) @(posedge clk);
        #1;
        check({4'h0, detection_enable}, 8'h0C);
        reg_read(8'h12, m_mode);
        finish_test();
    end
endmodule
